// >>> logic/add_with_carry_flag_unit.sv
`timescale 1ns/100ps

module add_with_carry_flag_unit
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Instruction control
    input  wire logic [2:0]  op,
    input  wire logic [7:0]  operand,
    output logic             done,
    // Accumulator and store path
    output logic [7:0]       acc,
    output logic [7:0]       store_data,
    output logic             store_valid,
    // Processor flags
    output logic             carry,
    output logic             zero,
    output logic             negative,
    output logic             overflow,
    output logic             decimal,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // Interrupt
    output logic             irq
);

    // ========================================
    // Reset release
    logic rst_n;

    reset_sync u_rst
    (
        .clk    (clk),
        .arst_n (arst_n),
        .rst_n  (rst_n)
    );

    // ========================================
    // State
    alu_pkg::op_t op_e;
    logic [7:0]   acc_q, acc_d;
    logic         c_q, c_d;
    logic         z_q, z_d;
    logic         n_q, n_d;
    logic         v_q, v_d;
    logic         d_q, d_d;
    logic [7:0]   sdata_q, sdata_d;
    logic         svalid_q, svalid_d;
    logic         done_q, done_d;
    logic [2:0]   stat_q, stat_d;
    logic [2:0]   mask_q, mask_d;
    logic [15:0]  count_q, count_d;
    logic [31:0]  rdata_q, rdata_d;
    logic         irq_q, irq_d;

    assign op_e = alu_pkg::op_t'(op);

    // ========================================
    // Adder: two digit stages in a carry chain
    digit_if lo ();
    digit_if hi ();

    digit_adder u_lo
    (
        .d (lo.adder)
    );

    digit_adder u_hi
    (
        .d (hi.adder)
    );

    logic [8:0] bin_sum;
    logic [7:0] res;
    logic       res_c;
    logic       res_v;

    always_comb
    begin
        lo.a   = acc_q[3:0];
        lo.b   = operand[3:0];
        lo.cin = c_q;            // [RULE_02]
        lo.dec = d_q;            // [RULE_10]
        hi.a   = acc_q[7:4];
        hi.b   = operand[7:4];
        hi.cin = lo.cout;        // [RULE_15]
        hi.dec = d_q;            // [RULE_11]
    end

    // Signed values use the very same adder; only the flags read them differently.
    always_comb
    begin
        bin_sum = {1'b0, acc_q} + {1'b0, operand} + {8'h00, c_q}; // [RULE_07]
        res     = {hi.sum, lo.sum};                               // [RULE_12]
        res_c   = hi.cout;                                        // [RULE_09]
        res_v   = ~(acc_q[7] ^ operand[7])
                & (acc_q[7] ^ bin_sum[7]);                        // [RULE_14]
    end

    // ========================================
    // Datapath and flag next state
    logic wr_acc;
    logic wr_flags;
    logic is_adc;

    always_comb
    begin
        wr_acc   = wr && (addr == alu_pkg::ACC_OFS);
        wr_flags = wr && (addr == alu_pkg::FLAGS_OFS);
        is_adc   = (op_e == alu_pkg::OP_ADC);
        acc_d    = wr_acc ? wdata[7:0] : acc_q;
        c_d      = wr_flags ? wdata[alu_pkg::C_BIT] : c_q;
        z_d      = wr_flags ? wdata[alu_pkg::Z_BIT] : z_q;
        d_d      = wr_flags ? wdata[alu_pkg::D_BIT] : d_q;
        v_d      = wr_flags ? wdata[alu_pkg::V_BIT] : v_q;
        n_d      = wr_flags ? wdata[alu_pkg::N_BIT] : n_q;
        sdata_d  = sdata_q;
        svalid_d = 1'b0;
        done_d   = 1'b0;
        count_d  = count_q;
        // An operation in the same cycle as a software write wins.
        unique case (op_e)
            alu_pkg::OP_NOP:
            begin
                done_d = 1'b0;
            end
            alu_pkg::OP_ADC:
            begin
                acc_d   = res;            // [RULE_01]
                c_d     = res_c;          // [RULE_01] [RULE_05] [RULE_12]
                v_d     = res_v;          // [RULE_08]
                z_d     = (res == 8'h00); // [RULE_13]
                n_d     = res[7];         // [RULE_06] [RULE_13]
                done_d  = 1'b1;
                count_d = count_q + 16'h0001;
            end
            alu_pkg::load_accumulator_op:
            begin
                acc_d  = operand;
                z_d    = (operand == 8'h00);
                n_d    = operand[7];
                done_d = 1'b1;
            end
            alu_pkg::store_accumulator_op:
            begin
                sdata_d  = acc_q;         // [RULE_03]
                svalid_d = 1'b1;
                done_d   = 1'b1;
            end
            alu_pkg::clear_carry_op:
            begin
                c_d    = 1'b0;            // [RULE_04]
                done_d = 1'b1;
            end
            alu_pkg::OP_SEC:
            begin
                c_d    = 1'b1;            // [RULE_04]
                done_d = 1'b1;
            end
            alu_pkg::set_decimal_mode_op:
            begin
                d_d    = 1'b1;            // [RULE_11]
                done_d = 1'b1;
            end
            alu_pkg::OP_CLD:
            begin
                d_d    = 1'b0;
                done_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q    <= alu_pkg::ACC_RST;
            c_q      <= alu_pkg::FLAGS_RST[alu_pkg::C_BIT];
            z_q      <= alu_pkg::FLAGS_RST[alu_pkg::Z_BIT];
            d_q      <= alu_pkg::FLAGS_RST[alu_pkg::D_BIT];
            v_q      <= alu_pkg::FLAGS_RST[alu_pkg::V_BIT];
            n_q      <= alu_pkg::FLAGS_RST[alu_pkg::N_BIT];
            sdata_q  <= alu_pkg::ACC_RST;
            svalid_q <= 1'b0;
            done_q   <= 1'b0;
            count_q  <= alu_pkg::COUNT_RST;
        end
        else
        begin
            acc_q    <= acc_d;
            c_q      <= c_d;
            z_q      <= z_d;
            d_q      <= d_d;
            v_q      <= v_d;
            n_q      <= n_d;
            sdata_q  <= sdata_d;
            svalid_q <= svalid_d;
            done_q   <= done_d;
            count_q  <= count_d;
        end
    end

    // ========================================
    // Interrupt status, mask and read port
    logic [7:0] flags_v;

    always_comb
    begin
        flags_v = 8'h00;
        flags_v[alu_pkg::C_BIT] = c_q;
        flags_v[alu_pkg::Z_BIT] = z_q;
        flags_v[alu_pkg::D_BIT] = d_q;
        flags_v[alu_pkg::V_BIT] = v_q;
        flags_v[alu_pkg::N_BIT] = n_q;
        mask_d = mask_q;
        stat_d = stat_q;
        if (wr && (addr == alu_pkg::MASK_OFS))
        begin
            mask_d = wdata[2:0];
        end
        if (wr && (addr == alu_pkg::STAT_OFS))
        begin
            stat_d = stat_q & ~wdata[2:0];
        end
        // A new event beats a clear in the same cycle.
        stat_d[alu_pkg::EV_CARRY] = stat_d[alu_pkg::EV_CARRY] | (is_adc & res_c);
        stat_d[alu_pkg::EV_OVF]   = stat_d[alu_pkg::EV_OVF] | (is_adc & res_v);
        stat_d[alu_pkg::EV_DONE]  = stat_d[alu_pkg::EV_DONE] | is_adc;
        irq_d   = |(stat_q & mask_q);
        rdata_d = 32'h0000_0000;
        if (rd)
        begin
            unique case (addr)
                alu_pkg::ACC_OFS:   rdata_d = {24'h00_0000, acc_q};
                alu_pkg::FLAGS_OFS: rdata_d = {24'h00_0000, flags_v};
                alu_pkg::STAT_OFS:  rdata_d = {29'h0000_0000, stat_q};
                alu_pkg::MASK_OFS:  rdata_d = {29'h0000_0000, mask_q};
                alu_pkg::COUNT_OFS: rdata_d = {16'h0000, count_q};
                default:            rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_q  <= alu_pkg::EV_RST;
            mask_q  <= alu_pkg::EV_RST;
            irq_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            irq_q   <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    // ========================================
    // Outputs
    assign acc         = acc_q;
    assign carry       = c_q;
    assign zero        = z_q;
    assign negative    = n_q;
    assign overflow    = v_q;
    assign decimal     = d_q;
    assign store_data  = sdata_q;
    assign store_valid = svalid_q;
    assign done        = done_q;
    assign rdata       = rdata_q;
    assign irq         = irq_q;

    // ========================================
    // Checks
    logic [7:0] dec_in;

    always_comb
    begin
        dec_in = 8'((acc_q[7:4] * 4'ha) + acc_q[3:0]
               + (operand[7:4] * 4'ha) + operand[3:0] + c_q);
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_adc_sum_acc: assert property ( // [RULE_01]
        is_adc && !d_q |=> acc_q == 8'($past(acc_q) + $past(operand) + $past(c_q)))
        else $error("binary sum not in accumulator");

    a_adc_carry_in: assert property ( // [RULE_02]
        is_adc && !d_q && c_q && operand == 8'h00 && acc_q == 8'hff
        |=> c_q && acc_q == 8'h00)
        else $error("carry input not added");

    a_store_keeps_c: assert property ( // [RULE_03]
        op_e == alu_pkg::store_accumulator_op && !wr_flags
        |=> c_q == $past(c_q) && v_q == $past(v_q))
        else $error("store changed flags");

    a_clear_carry: assert property ( // [RULE_04]
        op_e == alu_pkg::clear_carry_op |=> !c_q ##0 $stable(acc_q))
        else $error("carry not cleared");

    a_set_carry: assert property ( // [RULE_04]
        op_e == alu_pkg::OP_SEC |=> c_q)
        else $error("carry not set");

    a_carry_ninth: assert property ( // [RULE_09]
        is_adc && !d_q |=> c_q == $past(bin_sum[8]))
        else $error("carry is not the ninth bit");

    a_sign_zero: assert property ( // [RULE_13]
        is_adc |=> n_q == acc_q[7] && z_q == (acc_q == 8'h00))
        else $error("sign or zero flag wrong");

    a_ovf_signs: assert property ( // [RULE_08]
        is_adc |=> v_q == ($past(acc_q[7]) == $past(operand[7])
                       && $past(bin_sum[7]) != $past(acc_q[7])))
        else $error("overflow flag wrong");

    a_dec_persist: assert property ( // [RULE_11]
        d_q && op_e != alu_pkg::OP_CLD && !wr_flags |=> d_q)
        else $error("decimal mode dropped");

    a_dec_carry: assert property ( // [RULE_12]
        is_adc && d_q |=> c_q == ($past(dec_in) > alu_pkg::DEC_MAX))
        else $error("decimal carry wrong");

    a_irq_level: assert property (
        (stat_q & mask_q) != 3'h0 |=> irq)
        else $error("interrupt not raised");

    c_chain: cover property (is_adc && res_c ##1 op_e == alu_pkg::store_accumulator_op ##1 is_adc);
    c_dec_carry: cover property (is_adc && d_q && res_c);
    c_overflow: cover property (is_adc && res_v);
    c_irq: cover property (irq ##1 !irq);

endmodule

// >>> logic/alu_pkg.sv
// Contract
// RULE_01: An add-with-carry adds the operand to the accumulator, keeps the eight-bit sum and sets carry above 255.
// RULE_02: The carry left by one add is the carry input of the next add.
// RULE_03: A store of the accumulator leaves the carry flag as the last add left it.
// RULE_04: A clear-carry operation forces carry to zero, and a set-carry operation forces it to one.
// RULE_05: After the last add of a multi-byte sum, carry shows that the total overflowed the joint width.
// RULE_06: Bit 7 is the sign position and the sign flag copies bit 7 of the result.
// RULE_07: The same binary adder serves two's complement signed values unchanged.
// RULE_08: Overflow is set when the signed result leaves the range -128 to +127, and cleared otherwise.
// RULE_09: In signed adds carry is still the unsigned ninth bit, independent of overflow.
// RULE_10: A decimal mode adds bytes that hold two packed four-bit decimal digits.
// RULE_11: A decimal flag set by its own operation selects decimal and persists across adds.
// RULE_12: In decimal mode carry is set above 99 and the accumulator holds the corrected two digits.
// RULE_13: After each add, zero shows a zero result and negative copies result bit 7.
// RULE_14: Overflow is equal operand signs with a different result sign.
// RULE_15: In decimal mode each digit above nine is corrected by six and carries into the next digit.
package alu_pkg;

    // ========================================
    // Operations from instruction control
    typedef enum logic [2:0] {
        OP_NOP               = 3'b000,
        OP_ADC               = 3'b001,
        load_accumulator_op  = 3'b010,
        store_accumulator_op = 3'b011,
        clear_carry_op       = 3'b100,
        OP_SEC               = 3'b101,
        set_decimal_mode_op  = 3'b110,
        OP_CLD               = 3'b111
    } op_t;

    // ========================================
    // Register map
    localparam logic [7:0] ACC_OFS   = 8'h00;
    localparam logic [7:0] FLAGS_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS  = 8'h08;
    localparam logic [7:0] MASK_OFS  = 8'h0c;
    localparam logic [7:0] COUNT_OFS = 8'h10;

    // ========================================
    // Flag field positions
    localparam int C_BIT = 0;
    localparam int Z_BIT = 1;
    localparam int D_BIT = 3;
    localparam int V_BIT = 6;
    localparam int N_BIT = 7;

    // ========================================
    // Interrupt event positions
    localparam int EV_CARRY = 0;
    localparam int EV_OVF   = 1;
    localparam int EV_DONE  = 2;

    // ========================================
    // Reset values and digit limits
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [2:0]  EV_RST    = 3'h0;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [4:0]  DIGIT_MAX = 5'h09;
    localparam logic [4:0]  DIGIT_FIX = 5'h06;
    localparam logic [7:0]  DEC_MAX   = 8'h63;

endpackage

// >>> logic/digit_adder.sv
`timescale 1ns/100ps

module digit_adder
(
    // Digit operands and result
    digit_if.adder d
);
    logic [4:0] raw;
    logic [4:0] fixd;

    // A binary digit carries out of bit 4; a decimal digit above nine is fixed by six.
    always_comb
    begin
        raw    = {1'b0, d.a} + {1'b0, d.b} + {4'h0, d.cin};
        fixd   = raw + alu_pkg::DIGIT_FIX;
        d.sum  = raw[3:0];
        d.cout = raw[4];
        if (d.dec && (raw > alu_pkg::DIGIT_MAX))
        begin
            d.sum  = fixd[3:0]; // [RULE_15]
            d.cout = 1'b1;      // [RULE_15]
        end
    end
endmodule

// >>> logic/digit_if.sv
`timescale 1ns/100ps

interface digit_if;
    logic [3:0] a;
    logic [3:0] b;
    logic       cin;
    logic       dec;
    logic [3:0] sum;
    logic       cout;

    modport user
    (
        output a, b, cin, dec,
        input  sum, cout
    );
    modport adder
    (
        input  a, b, cin, dec,
        output sum, cout
    );
endinterface

// >>> logic/reset_sync.sv
`timescale 1ns/100ps

module reset_sync
(
    // Clock and raw reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Released reset
    output logic      rst_n
);
    logic meta_q;
    logic rel_q;

    // Assert at once, release after two edges.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= 1'b0;
            rel_q  <= 1'b0;
        end
        else
        begin
            meta_q <= 1'b1;
            rel_q  <= meta_q;
        end
    end

    assign rst_n = rel_q;
endmodule

// >>> testbench/add_with_carry_flag_unit_tb.sv
`timescale 1ns/100ps

module add_with_carry_flag_unit_tb;
    logic        clk;
    logic        arst_n;
    logic [2:0]  op;
    logic [7:0]  operand;
    logic        done;
    logic [7:0]  acc;
    logic [7:0]  store_data;
    logic        store_valid;
    logic        carry, zero, negative, overflow, decimal;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr, rd;
    logic [31:0] rdata;
    logic        irq;
    logic [7:0]  mem_byte;
    logic [7:0]  ea;
    logic        ec, ev, ed, ez, en;
    logic [15:0] adc_n, xa, xb;
    int          fail_count, samples_checked;

    add_with_carry_flag_unit dut
    (
        .clk(clk), .arst_n(arst_n), .op(op), .operand(operand), .done(done),
        .acc(acc), .store_data(store_data), .store_valid(store_valid),
        .carry(carry), .zero(zero), .negative(negative), .overflow(overflow),
        .decimal(decimal), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq)
    );

    store_memory mem
    (
        .clk(clk), .store_data(store_data), .store_valid(store_valid), .mem_byte(mem_byte)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ========================================
    // Comparison and closing
    task check_data(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task check_flags(input logic [4:0] got, input logic [4:0] exp);
        check_data({27'h0, got}, {27'h0, exp});
    endtask

    task wrap_up;
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ========================================
    // Expected result: {carry, overflow, sum}
    function automatic logic [9:0] adc_exp(input logic [7:0] a, m, input logic c, d);
        logic [8:0] s;
        logic [4:0] lo, hi;
        logic       v;
        s = {1'b0, a} + {1'b0, m} + {8'h00, c};
        v = (a[7] == m[7]) && (s[7] != a[7]);
        if (!d)
            return {s[8], v, s[7:0]};
        lo = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, c};
        if (lo > 5'h09)
            lo = lo + 5'h06;
        hi = {1'b0, a[7:4]} + {1'b0, m[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09)
            hi = hi + 5'h06;
        return {hi[4], v, hi[3:0], lo[3:0]};
    endfunction

    // ========================================
    // Bus tasks
    task do_op(input alu_pkg::op_t o, input logic [7:0] m);
        logic [9:0] r;
        logic [4:0] f, e;
        r = adc_exp(ea, m, ec, ed);
        @(posedge clk);
        op <= o;
        operand <= m;
        @(posedge clk);
        op <= alu_pkg::OP_NOP;
        #1;
        // Zero and negative follow only adds and loads.
        case (o)
            alu_pkg::OP_ADC:
            begin
                {ec, ev, ea} = r;
                {ez, en} = {r[7:0] == 8'h00, r[7]};
                adc_n++;
            end
            alu_pkg::load_accumulator_op:
            begin
                ea = m;
                {ez, en} = {m == 8'h00, m[7]};
            end
            alu_pkg::clear_carry_op: ec = 1'b0;
            alu_pkg::OP_SEC: ec = 1'b1;
            alu_pkg::set_decimal_mode_op: ed = 1'b1;
            alu_pkg::OP_CLD: ed = 1'b0;
            default: ;
        endcase
        f = {carry, zero, negative, overflow, decimal};
        e = {ec, ez, en, ev, ed};
        check_data(done, o != alu_pkg::OP_NOP);
        check_data(acc, ea);
        check_flags(f, e);
        check_data(store_valid, o == alu_pkg::store_accumulator_op);
        if (o == alu_pkg::store_accumulator_op)
            check_data(store_data, ea);
    endtask

    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check_data(rdata, e);
    endtask

    initial
    begin
        #80000;
        fail_count++;
        wrap_up;
    end

    // ========================================
    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        op = alu_pkg::OP_NOP;
        operand = 8'h00;
        addr = 8'h00;
        wdata = 32'h0;
        {wr, rd} = 2'b00;
        {fail_count, samples_checked} = '0;
        {ea, ec, ev, ed, ez, en, adc_n} = '0;
        void'($urandom(26));
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        reg_rd(alu_pkg::STAT_OFS, 32'h0);
        // Two-byte sums: carry chains and shows the 16-bit overflow.
        for (int i = 0; i < 12; i++)
        begin
            xa = (i == 0) ? 16'h0180 : (i == 1) ? 16'hffff : 16'($urandom);
            xb = (i == 0) ? 16'h0080 : (i == 1) ? 16'h0001 : 16'($urandom);
            do_op(alu_pkg::clear_carry_op, 8'h00);
            do_op(alu_pkg::load_accumulator_op, xa[7:0]);
            do_op(alu_pkg::OP_ADC, xb[7:0]);
            do_op(alu_pkg::store_accumulator_op, 8'h00);
            do_op(alu_pkg::load_accumulator_op, xa[15:8]);
            do_op(alu_pkg::OP_ADC, xb[15:8]);
            check_data({carry, acc, mem_byte}, {1'b0, xa} + {1'b0, xb});
        end
        // A carry in alone must ripple through an all-ones accumulator.
        do_op(alu_pkg::OP_SEC, 8'h00);
        do_op(alu_pkg::load_accumulator_op, 8'hff);
        do_op(alu_pkg::OP_ADC, 8'h00);
        // Signed corner pairs.
        for (int j = 0; j < 16; j++)
        begin
            xb = (j % 2) ? {8'h7f, 8'h02} : {8'hbe, 8'hbf};
            do_op(alu_pkg::OP_SEC, 8'h00);
            do_op(alu_pkg::load_accumulator_op, xb[15:8]);
            do_op(alu_pkg::OP_ADC, xb[7:0]);
            do_op(alu_pkg::load_accumulator_op, 8'h05);
            do_op(alu_pkg::OP_ADC, (j % 2) ? 8'hfd : 8'hf9);
        end
        // Decimal mode persists over many adds.
        do_op(alu_pkg::clear_carry_op, 8'h00);
        do_op(alu_pkg::set_decimal_mode_op, 8'h00);
        do_op(alu_pkg::load_accumulator_op, 8'h79);
        do_op(alu_pkg::OP_ADC, 8'h14);
        check_data(acc, 8'h93);
        repeat (40)
            do_op(alu_pkg::OP_ADC, {4'($urandom % 10), 4'($urandom % 10)});
        do_op(alu_pkg::OP_CLD, 8'h00);
        // Random binary traffic.
        repeat (300)
        begin
            xa[2:0] = 3'($urandom % 7);
            do_op(alu_pkg::op_t'((xa[2:0] == 3'h6) ? 3'h7 : xa[2:0]), 8'($urandom));
        end
        // Register port.
        reg_wr(alu_pkg::ACC_OFS, 32'h5a);
        reg_wr(alu_pkg::FLAGS_OFS, 32'h01);
        {ea, ec, ev, ed, ez, en} = {8'h5a, 5'b10000};
        reg_rd(alu_pkg::ACC_OFS, 32'h5a);
        reg_rd(alu_pkg::FLAGS_OFS, 32'h01);
        reg_wr(8'h14, 32'hff);
        reg_rd(8'h14, 32'h0);
        // Interrupt: raise, read, clear, masked event.
        reg_wr(alu_pkg::STAT_OFS, 32'h7);
        reg_wr(alu_pkg::MASK_OFS, 32'h1);
        reg_rd(alu_pkg::MASK_OFS, 32'h1);
        do_op(alu_pkg::load_accumulator_op, 8'hff);
        do_op(alu_pkg::OP_ADC, 8'h01);
        @(posedge clk);
        #1;
        check_data(irq, 1'b1);
        reg_rd(alu_pkg::STAT_OFS, 32'h5);
        reg_wr(alu_pkg::STAT_OFS, 32'h1);
        @(posedge clk);
        #1;
        check_data(irq, 1'b0);
        reg_rd(alu_pkg::STAT_OFS, 32'h4);
        reg_rd(alu_pkg::COUNT_OFS, {16'h0, adc_n});
        wrap_up;
    end
endmodule

// >>> testbench/store_memory.sv
`timescale 1ns/100ps

module store_memory
(
    // Clock
    input  wire logic       clk,
    // Store path from the accumulator
    input  wire logic [7:0] store_data,
    input  wire logic       store_valid,
    // Byte last written to memory
    output logic [7:0]      mem_byte
);
    // Memory takes the byte only on the store pulse.
    always_ff @(posedge clk)
    begin
        if (store_valid)
        begin
            mem_byte <= store_data;
        end
    end
endmodule
